// >>> shared/cctc_pkg.sv
// Package of constants and types for the CPU clock tree control block
package cctc_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [15:0] CCTC_CLOCK_CONTROL_ADDR = 16'hFFDE;
    localparam logic [7:0] CCTC_TRIM_ADDR = 8'h96;
    localparam logic [7:0] CCTC_AUX_ONE_ADDR = 8'hA2;

    // ----------------------------------------------------------------
    // Clock control fields
    // ----------------------------------------------------------------
    localparam int CCTC_DONE_BIT = 7;
    localparam int CCTC_WDOG_SPEED_BIT = 5;
    localparam int CCTC_XTAL_WDOG_BIT = 4;
    localparam int CCTC_DOUBLER_BIT = 3;
    localparam int CCTC_OSC_SEL_LSB = 0;
    localparam int CCTC_OSC_SEL_W = 3;

    // ----------------------------------------------------------------
    // Trim register fields and the low-power bit
    // ----------------------------------------------------------------
    localparam int CCTC_RC_CPU_BIT = 7;
    localparam int CCTC_CLK_OUT_EN_BIT = 6;
    localparam int CCTC_TRIM_W = 6;
    localparam int CCTC_LOW_POWER_BIT = 7;

    // ----------------------------------------------------------------
    // Configuration byte fields
    // ----------------------------------------------------------------
    localparam int CCTC_CFG1_DOUBLER_BIT = 7;
    localparam int CCTC_CFG2_DOUBLER_BIT = 7;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CCTC_TRIM_CTRL_RESET = 8'h00;
    localparam logic [7:0] CCTC_AUX_ONE_RESET = 8'h00;
    localparam logic [5:0] CCTC_FACTORY_TRIM_DEFAULT = 6'h20;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CCTC_MACHINE_CYCLE_CPU_CLOCK = 2;
    localparam int CCTC_PCLK_DIV = 2;
    localparam int CCTC_SYNC_STAGES = 2;
    localparam int CCTC_LOW_POWER_MAX_MHZ = 8;
    localparam int CCTC_RC_NOMINAL_KHZ = 7373;
    localparam int CCTC_RC_DOUBLE_KHZ = 14746;
    localparam int CCTC_WDOG_FAST_KHZ = 400;
    localparam int CCTC_WDOG_SLOW_KHZ = 25;

    // ----------------------------------------------------------------
    // Oscillator source codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CCTC_SRC_XTAL = 3'h0,
        CCTC_SRC_EXT = 3'h3,
        CCTC_SRC_WDOG = 3'h4,
        CCTC_SRC_RC = 3'h7
    } cctc_src_type;

    // Switch sequencer states, Gray coded along the path
    typedef enum logic [1:0] {
        CCTC_SW_IDLE = 2'b00,
        CCTC_SW_DROP = 2'b01,
        CCTC_SW_WAIT = 2'b11,
        CCTC_SW_PICK = 2'b10
    } cctc_sw_state_type;

    function automatic logic [1:0] cctc_src_index(input logic [2:0] code);
        case (code)
            3'h0: cctc_src_index = 2'd0;
            3'h3: cctc_src_index = 2'd1;
            3'h4: cctc_src_index = 2'd2;
            default: cctc_src_index = 2'd3;
        endcase
    endfunction

endpackage

// >>> shared/cctc_sw_if.sv
// Interface between the switch sequencer and the glitch-free mux
`timescale 1ns/1ps
interface cctc_sw_if;
    logic [1:0] new_sel;
    logic start;
    logic done;
    logic [1:0] active_sel;

    modport ctrl (output new_sel, output start, input done,
        input active_sel);
    modport mux (input new_sel, input start, output done,
        output active_sel);
endinterface

// >>> src/cctc_sync.sv
// Two-stage synchroniser for a bus of levels
`timescale 1ns/1ps
module cctc_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    initial begin
        if (WIDTH < 1) begin
            $error("cctc_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule

// >>> src/cctc_glitch_mux.sv
// Glitch-free selection of one of four source clock enables
`timescale 1ns/1ps
module cctc_glitch_mux (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] src_tick_i,
    cctc_sw_if.mux sw,
    output logic osc_tick_o
);
    import cctc_pkg::*;

    logic [1:0] cur_q;
    logic gate_q;
    logic [1:0] wait_q;
    logic busy_q;

    // ----------------------------------------------------------------
    // Gate off, let old and new sources settle, then reopen
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_q <= 2'd0;
            gate_q <= 1'b1;
            wait_q <= 2'd0;
            busy_q <= 1'b0;
        end else if (sw.start) begin
            gate_q <= 1'b0;
            busy_q <= 1'b1;
            wait_q <= 2'(CCTC_SYNC_STAGES);
            cur_q <= sw.new_sel;
        end else if (busy_q) begin
            if (wait_q != 2'd0) begin
                wait_q <= wait_q - 2'd1;
            end else if (src_tick_i[cur_q]) begin
                // Reopen only on a tick of the new source
                gate_q <= 1'b1;
                busy_q <= 1'b0;
            end
        end
    end

    assign osc_tick_o = gate_q & src_tick_i[cur_q];
    assign sw.done = ~busy_q;
    assign sw.active_sel = cur_q;
endmodule

// >>> src/cctc_top.sv
// CPU clock tree control: source select, divider, trim and clock output
`timescale 1ns/1ps
module cctc_top #(
    parameter int DIV_W = 8,
    parameter logic [5:0] FACTORY_TRIM = cctc_pkg::CCTC_FACTORY_TRIM_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Special function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    // External data port
    input wire logic [15:0] xdata_addr_i,
    input wire logic xdata_wr_i,
    input wire logic xdata_rd_i,
    input wire logic [7:0] xdata_wdata_i,
    output logic [7:0] xdata_rdata_o,
    output logic xdata_hit_o,
    // Divider setting from the CPU clock divider register
    input wire logic [DIV_W-1:0] cpu_clock_divider_i,
    // Configuration bytes
    input wire logic [7:0] config_byte_one_i,
    input wire logic [7:0] config_byte_two_i,
    // Source clocks as asynchronous levels, then RTC crystal use and watchdog clock enable
    input wire logic crystal_clk_i,
    input wire logic ext_clk_i,
    input wire logic wdog_clk_i,
    input wire logic rc_clk_i,
    input wire logic rtc_uses_crystal_i,
    input wire logic wdog_clock_en_i,
    // Oscillator controls
    output logic [5:0] rc_trim_o,
    output logic rc_doubler_en_o,
    output logic wdog_osc_speed_sel_o,
    output logic crystal_for_wdog_o,
    output logic low_power_clocking_o,
    // Clock enables
    output logic osc_clock_o,
    output logic cpu_clock_o,
    output logic periph_clock_o,
    output logic machine_cycle_o,
    // Clock output pin
    output logic clock_output_pin_o,
    output logic clock_output_pin_oe_o
);
    import cctc_pkg::*;

    initial begin
        if (DIV_W < 1 || DIV_W > 16) begin
            $error("cctc_top: DIV_W must be 1 to 16");
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [2:0] osc_sel_q;
    logic doubler_q;
    logic xtal_wdog_q;
    logic wdog_speed_q;
    logic rc_cpu_q;
    logic clk_out_en_q;
    logic [5:0] trim_q;
    logic low_power_q;
    logic [7:0] sfr_rdata_q;
    logic [7:0] xdata_rdata_q;
    logic xdata_hit_q;
    logic strap_done_q;

    logic [3:0] src_sync;
    logic [3:0] src_prev_q;
    logic [3:0] src_tick;
    logic osc_tick;
    logic switch_done;

    cctc_sw_if sw_bus ();

    wire clk_ctrl_sel = xdata_addr_i == CCTC_CLOCK_CONTROL_ADDR;
    // Writes during a switch are dropped
    wire clk_ctrl_wr = xdata_wr_i & clk_ctrl_sel & switch_done;
    wire trim_wr = sfr_wr_i & (sfr_addr_i == CCTC_TRIM_ADDR);
    wire aux_wr = sfr_wr_i & (sfr_addr_i == CCTC_AUX_ONE_ADDR);

    // ----------------------------------------------------------------
    // Source clock synchronisers and tick detection
    // ----------------------------------------------------------------
    cctc_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({rc_clk_i, wdog_clk_i, ext_clk_i, crystal_clk_i}),
        .sync_o(src_sync)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_prev_q <= 4'h0;
        end else begin
            src_prev_q <= src_sync;
        end
    end

    assign src_tick = src_sync & ~src_prev_q;

    // ----------------------------------------------------------------
    // Clock control register, strapped from configuration byte one
    // ----------------------------------------------------------------
    // Strap is caught by a clocked process right after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_done_q <= 1'b0;
            osc_sel_q <= 3'h0;
            doubler_q <= 1'b0;
            xtal_wdog_q <= 1'b0;
            wdog_speed_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            osc_sel_q <= config_byte_one_i[2:0];
            doubler_q <= config_byte_one_i[CCTC_CFG1_DOUBLER_BIT];
        end else if (clk_ctrl_wr) begin
            osc_sel_q <= xdata_wdata_i[CCTC_OSC_SEL_LSB +: CCTC_OSC_SEL_W];
            doubler_q <= xdata_wdata_i[CCTC_DOUBLER_BIT];
            xtal_wdog_q <= xdata_wdata_i[CCTC_XTAL_WDOG_BIT];
            wdog_speed_q <= xdata_wdata_i[CCTC_WDOG_SPEED_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Trim register and low-power bit
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rc_cpu_q <= CCTC_TRIM_CTRL_RESET[CCTC_RC_CPU_BIT];
            clk_out_en_q <= CCTC_TRIM_CTRL_RESET[CCTC_CLK_OUT_EN_BIT];
            trim_q <= FACTORY_TRIM;
        end else if (trim_wr) begin
            rc_cpu_q <= sfr_wdata_i[CCTC_RC_CPU_BIT];
            clk_out_en_q <= sfr_wdata_i[CCTC_CLK_OUT_EN_BIT];
            trim_q <= sfr_wdata_i[CCTC_TRIM_W-1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_power_q <= CCTC_AUX_ONE_RESET[CCTC_LOW_POWER_BIT];
        end else if (aux_wr) begin
            low_power_q <= sfr_wdata_i[CCTC_LOW_POWER_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Switch sequencer
    // ----------------------------------------------------------------
    cctc_sw_state_type sw_state_q;
    logic [1:0] want_sel;

    // RC select overrides the source field at once
    assign want_sel = rc_cpu_q ? 2'd3 : cctc_src_index(osc_sel_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_state_q <= CCTC_SW_IDLE;
        end else begin
            unique case (sw_state_q)
                CCTC_SW_IDLE: begin
                    if (strap_done_q && want_sel != sw_bus.active_sel) begin
                        sw_state_q <= CCTC_SW_DROP;
                    end
                end
                CCTC_SW_DROP: sw_state_q <= CCTC_SW_WAIT;
                CCTC_SW_WAIT: begin
                    if (sw_bus.done) begin
                        sw_state_q <= CCTC_SW_PICK;
                    end
                end
                CCTC_SW_PICK: sw_state_q <= CCTC_SW_IDLE;
            endcase
        end
    end

    assign sw_bus.start = sw_state_q == CCTC_SW_DROP;
    assign sw_bus.new_sel = want_sel;
    // Flag falls on switch start, rises when finished
    assign switch_done = sw_state_q == CCTC_SW_IDLE;

    cctc_glitch_mux u_mux (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .src_tick_i(src_tick),
        .sw(sw_bus.mux),
        .osc_tick_o(osc_tick)
    );

    // ----------------------------------------------------------------
    // CPU clock divider, peripheral clock, machine cycle
    // ----------------------------------------------------------------
    logic [DIV_W-1:0] div_cnt_q;
    logic cpu_tick_q;
    logic pclk_phase_q;
    logic out_level_q;

    // Divider value N gives osc/(N+1); a count reload avoids a gap
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_q <= '0;
            cpu_tick_q <= 1'b0;
        end else begin
            cpu_tick_q <= 1'b0;
            if (osc_tick) begin
                if (div_cnt_q >= cpu_clock_divider_i) begin
                    div_cnt_q <= '0;
                    cpu_tick_q <= 1'b1;
                end else begin
                    div_cnt_q <= div_cnt_q + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pclk_phase_q <= 1'b0;
            out_level_q <= 1'b0;
        end else if (cpu_tick_q) begin
            pclk_phase_q <= ~pclk_phase_q;
            out_level_q <= ~out_level_q;
        end
    end

    assign osc_clock_o = osc_tick;
    assign cpu_clock_o = cpu_tick_q;
    assign periph_clock_o = cpu_tick_q & pclk_phase_q;
    assign machine_cycle_o = cpu_tick_q & pclk_phase_q;

    // ----------------------------------------------------------------
    // Clock output pin
    // ----------------------------------------------------------------
    // Crystal counts as used by CPU, RTC or watchdog
    wire xtal_for_cpu = sw_bus.active_sel == 2'd0;
    wire xtal_busy = xtal_for_cpu | rtc_uses_crystal_i |
        (wdog_clock_en_i & xtal_wdog_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clock_output_pin_oe_o <= 1'b0;
            clock_output_pin_o <= 1'b0;
        end else begin
            clock_output_pin_oe_o <= clk_out_en_q & ~xtal_busy;
            clock_output_pin_o <= out_level_q;
        end
    end

    // ----------------------------------------------------------------
    // Oscillator controls
    // ----------------------------------------------------------------
    assign rc_trim_o = trim_q;
    // Either the doubler bit or config byte two doubles the RC
    assign rc_doubler_en_o = doubler_q |
        config_byte_two_i[CCTC_CFG2_DOUBLER_BIT];
    assign wdog_osc_speed_sel_o = wdog_speed_q;
    assign crystal_for_wdog_o = xtal_wdog_q;
    assign low_power_clocking_o = low_power_q;

    // ----------------------------------------------------------------
    // Read ports
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_addr_i == CCTC_TRIM_ADDR) begin
            sfr_rdata_q <= {rc_cpu_q, clk_out_en_q, trim_q};
        end else if (sfr_addr_i == CCTC_AUX_ONE_ADDR) begin
            sfr_rdata_q <= {low_power_q, 7'h00};
        end else begin
            sfr_rdata_q <= 8'h00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xdata_rdata_q <= 8'h00;
            xdata_hit_q <= 1'b0;
        end else begin
            xdata_hit_q <= (xdata_rd_i | xdata_wr_i) & clk_ctrl_sel;
            if (xdata_rd_i && clk_ctrl_sel) begin
                xdata_rdata_q <= {switch_done, 1'b0, wdog_speed_q,
                    xtal_wdog_q, doubler_q, osc_sel_q};
            end else begin
                xdata_rdata_q <= 8'h00;
            end
        end
    end

    assign sfr_rdata_o = sfr_rdata_q;
    assign xdata_rdata_o = xdata_rdata_q;
    assign xdata_hit_o = xdata_hit_q;
endmodule

// >>> testbench/cctc_top_chk.sv
// Port checker for the CPU clock tree control block, with its bind
`timescale 1ns/1ps
module cctc_top_chk #(
    parameter logic [5:0] FACTORY_TRIM = cctc_pkg::CCTC_FACTORY_TRIM_DEFAULT
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic [15:0] xdata_addr_i,
    input wire logic xdata_wr_i,
    input wire logic xdata_rd_i,
    input wire logic [7:0] xdata_rdata_o,
    input wire logic xdata_hit_o,
    input wire logic [7:0] config_byte_two_i,
    input wire logic [5:0] rc_trim_o,
    input wire logic rc_doubler_en_o,
    input wire logic low_power_clocking_o,
    input wire logic cpu_clock_o,
    input wire logic periph_clock_o,
    input wire logic clock_output_pin_oe_o
);
    import cctc_pkg::*;
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic x_acc;
    logic trim_wr;
    logic aux_wr;
    logic en_q;
    logic seen_q;
    logic [2:0] cnt_q;
    assign x_acc = (xdata_rd_i || xdata_wr_i) &&
        xdata_addr_i == CCTC_CLOCK_CONTROL_ADDR;
    assign trim_wr = sfr_wr_i && sfr_addr_i == CCTC_TRIM_ADDR;
    assign aux_wr = sfr_wr_i && sfr_addr_i == CCTC_AUX_ONE_ADDR;
    // Enable bit mirrored from the write port, as software would see it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q <= 1'b0;
        end else if (trim_wr) begin
            en_q <= sfr_wdata_i[CCTC_CLK_OUT_EN_BIT];
        end
    end
    // CPU ticks between peripheral ticks; works whatever their phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seen_q <= 1'b0;
            cnt_q <= 3'h0;
        end else if (periph_clock_o) begin
            seen_q <= 1'b1;
            cnt_q <= 3'h0;
        end else if (cpu_clock_o && cnt_q != 3'h7) begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_XHIT:
    assert property (##1 xdata_hit_o == $past(x_acc))
        else $error("hit flag does not follow access");
    AST_XRD_ZERO:
    assert property (xdata_rd_i && !x_acc |=> xdata_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_RSV_ZERO:
    assert property (xdata_hit_o |-> !xdata_rdata_o[6])
        else $error("reserved bit set");
    AST_TRIM_WR:
    assert property (trim_wr |=> rc_trim_o == $past(sfr_wdata_i[5:0]))
        else $error("trim write lost");
    AST_TRIM_RD:
    assert property (sfr_addr_i == CCTC_TRIM_ADDR |=>
        sfr_rdata_o[5:0] == $past(rc_trim_o))
        else $error("trim read wrong");
    AST_LP_WR:
    assert property (aux_wr |=>
        low_power_clocking_o == $past(sfr_wdata_i[7]))
        else $error("low power bit wrong");
    AST_DBL:
    assert property (config_byte_two_i[7] [*2] |-> rc_doubler_en_o)
        else $error("doubler off with strap set");
    AST_RST_VAL:
    assert property ($fell(rst_i) |-> rc_trim_o == FACTORY_TRIM &&
        !low_power_clocking_o && !clock_output_pin_oe_o)
        else $error("reset values wrong");
    AST_OE_EN:
    assert property (clock_output_pin_oe_o |-> $past(en_q))
        else $error("pin driven while disabled");
    AST_PCLK:
    assert property (periph_clock_o && seen_q |->
        cnt_q + {2'b00, cpu_clock_o} == 3'h2)
        else $error("peripheral tick not every second cpu tick");
    COV_TRIM: cover property (trim_wr);
    COV_HIT: cover property (x_acc ##1 xdata_hit_o);
    COV_PCLK: cover property (periph_clock_o && seen_q);
    COV_DBL: cover property (config_byte_two_i[7] [*2]);
endmodule

bind cctc_top cctc_top_chk #(.FACTORY_TRIM(FACTORY_TRIM)) cctc_top_chk_inst (
    .clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .xdata_addr_i(xdata_addr_i),
    .xdata_wr_i(xdata_wr_i), .xdata_rd_i(xdata_rd_i),
    .xdata_rdata_o(xdata_rdata_o), .xdata_hit_o(xdata_hit_o),
    .config_byte_two_i(config_byte_two_i), .rc_trim_o(rc_trim_o),
    .rc_doubler_en_o(rc_doubler_en_o),
    .low_power_clocking_o(low_power_clocking_o),
    .cpu_clock_o(cpu_clock_o), .periph_clock_o(periph_clock_o),
    .clock_output_pin_oe_o(clock_output_pin_oe_o));

// >>> testbench/test_cpu_clock_tree_control.sv
// Self-checking bench for the CPU clock tree control block
`timescale 1ns/1ps
module test_cpu_clock_tree_control;
    import cctc_pkg::*;
    logic clk_i, rst_i, sfr_wr_i, xdata_wr_i, xdata_rd_i, rtc, wden;
    logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, xdata_wdata_i;
    logic [7:0] xdata_rdata_o, div, cfg1, cfg2, v;
    logic [15:0] xdata_addr_i;
    logic [5:0] rc_trim;
    logic hit, dbl, wsp, xwd, lp, osc, cpu, per, mc, pin, oe, pin_q;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n_osc = 0, n_cpu = 0, n_per = 0, n_mc = 0, n_tog = 0;
    int d_osc, d_cpu, d_per, d_mc, d_tog;
    logic [2:0] codes [4] = '{3'h0, 3'h3, 3'h4, 3'h7};
    int per_tab [4] = '{8, 10, 128, 6};

    cctc_top cctc_top_inst (.clk_i(clk_i), .rst_i(rst_i),
        .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .xdata_addr_i(xdata_addr_i), .xdata_wr_i(xdata_wr_i),
        .xdata_rd_i(xdata_rd_i), .xdata_wdata_i(xdata_wdata_i),
        .xdata_rdata_o(xdata_rdata_o), .xdata_hit_o(hit),
        .cpu_clock_divider_i(div), .config_byte_one_i(cfg1),
        .config_byte_two_i(cfg2), .crystal_clk_i(cyc[2]),
        .ext_clk_i((cyc % 10) < 5), .wdog_clk_i(cyc[6]),
        .rc_clk_i((cyc % 6) < 3), .rtc_uses_crystal_i(rtc),
        .wdog_clock_en_i(wden), .rc_trim_o(rc_trim),
        .rc_doubler_en_o(dbl), .wdog_osc_speed_sel_o(wsp),
        .crystal_for_wdog_o(xwd), .low_power_clocking_o(lp),
        .osc_clock_o(osc), .cpu_clock_o(cpu), .periph_clock_o(per),
        .machine_cycle_o(mc), .clock_output_pin_o(pin),
        .clock_output_pin_oe_o(oe));

    // ------------------------------------------------------------
    // Clock, source oscillators, tick counters
    // ------------------------------------------------------------
    initial begin
        clk_i = 0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) cyc <= #1 cyc + 1;
    // Counted mid-cycle so combinational pulses have settled
    always @(negedge clk_i) begin
        n_osc += (osc === 1'b1);
        n_cpu += (cpu === 1'b1);
        n_per += (per === 1'b1);
        n_mc += (mc === 1'b1);
        n_tog += (pin !== pin_q);
        pin_q = pin;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("ERROR %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic sfr(input logic [7:0] a, input logic w,
        input logic [7:0] d, output logic [7:0] r);
        @(posedge clk_i) #1;
        sfr_addr_i = a;
        sfr_wr_i = w;
        sfr_wdata_i = d;
        @(posedge clk_i) #1;
        sfr_wr_i = 0;
        r = sfr_rdata_o;
    endtask
    task automatic xd(input logic [15:0] a, input logic w,
        input logic [7:0] d, output logic [7:0] r);
        @(posedge clk_i) #1;
        xdata_addr_i = a;
        xdata_wr_i = w;
        xdata_rd_i = !w;
        xdata_wdata_i = d;
        @(posedge clk_i) #1;
        xdata_wr_i = 0;
        xdata_rd_i = 0;
        r = xdata_rdata_o;
    endtask
    // Polls the switch flag; a stuck switch shows as a mismatch
    task automatic wait_done();
        for (int i = 0; i < 100; i++) begin
            xd(CCTC_CLOCK_CONTROL_ADDR, 0, 0, v);
            if (v[7] === 1'b1) break;
        end
    endtask
    task automatic measure(input int n);
        int a, b, c, d, e;
        a = n_osc;
        b = n_cpu;
        c = n_per;
        d = n_mc;
        e = n_tog;
        repeat (n) @(posedge clk_i);
        #1;
        d_osc = n_osc - a;
        d_cpu = n_cpu - b;
        d_per = n_per - c;
        d_mc = n_mc - d;
        d_tog = n_tog - e;
    endtask
    // The strap starts a switch to its source, so poll until it settles
    task automatic check_reset();
        wait_done();
        chk(v, 8'h8B);
        chk(hit, 1);
        chk(dbl, 1);
        sfr(CCTC_TRIM_ADDR, 0, 0, v);
        chk(v, {2'b00, CCTC_FACTORY_TRIM_DEFAULT});
        sfr(CCTC_AUX_ONE_ADDR, 0, 0, v);
        chk(v, 8'h00);
    endtask
    task automatic complete_run();
        if (fail_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #400000;
        fail_count++;
        complete_run();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst_i = 1;
        {sfr_addr_i, sfr_wr_i, sfr_wdata_i, xdata_addr_i} = '0;
        {xdata_wr_i, xdata_rd_i, xdata_wdata_i, div, rtc, wden} = '0;
        cfg2 = 0;
        cfg1 = 8'hBB;
        repeat (16) @(posedge clk_i);
        #1 rst_i = 0;
        repeat (2) @(posedge clk_i);
        check_reset();
        xd(16'hFFDF, 0, 0, v);
        chk(v, 8'h00);
        chk(hit, 0);
        for (int k = 0; k < 4; k++) begin
            xd(CCTC_CLOCK_CONTROL_ADDR, 1, {5'h00, codes[k]}, v);
            wait_done();
            chk(v, {5'h10, codes[k]});
            measure(640);
            chk_rng(d_osc, 640 / per_tab[k] - 1, 640 / per_tab[k] + 2);
            chk_rng(d_cpu, 640 / per_tab[k] - 1, 640 / per_tab[k] + 2);
        end
        div = 2;
        sfr(CCTC_TRIM_ADDR, 0, 0, v);
        sfr(CCTC_TRIM_ADDR, 1, v | 8'h40, v);
        measure(1200);
        chk_rng(d_cpu, 65, 68);
        chk_rng(d_per, 32, 35);
        chk_rng(d_mc, 32, 35);
        chk_rng(d_tog, 65, 68);
        chk(oe, 1);
        sfr(CCTC_TRIM_ADDR, 0, 0, v);
        chk(v, 8'h60);
        rtc = 1;
        repeat (8) @(posedge clk_i);
        #1 chk(oe, 0);
        rtc = 0;
        wden = 1;
        xd(CCTC_CLOCK_CONTROL_ADDR, 1, 8'h37, v);
        wait_done();
        chk(v, 8'hB7);
        chk({xwd, wsp}, 2'b11);
        chk(oe, 0);
        wden = 0;
        xd(CCTC_CLOCK_CONTROL_ADDR, 1, 8'h00, v);
        wait_done();
        chk(oe, 0);
        sfr(CCTC_TRIM_ADDR, 1, 8'hA0, v);
        repeat (20) @(posedge clk_i);
        measure(1200);
        chk_rng(d_osc, 199, 202);
        sfr(CCTC_TRIM_ADDR, 1, 8'h20, v);
        repeat (20) @(posedge clk_i);
        measure(1200);
        chk_rng(d_osc, 149, 152);
        xd(CCTC_CLOCK_CONTROL_ADDR, 1, 8'hC4, v);
        repeat (2) @(posedge clk_i);
        xd(CCTC_CLOCK_CONTROL_ADDR, 0, 0, v);
        chk(v, 8'h04);
        xd(CCTC_CLOCK_CONTROL_ADDR, 1, 8'h07, v);
        wait_done();
        chk(v, 8'h84);
        cfg2 = 8'h80;
        repeat (3) @(posedge clk_i);
        #1 chk(dbl, 1);
        cfg2 = 0;
        repeat (3) @(posedge clk_i);
        #1 chk(dbl, 0);
        sfr(CCTC_AUX_ONE_ADDR, 1, 8'h80, v);
        sfr(CCTC_AUX_ONE_ADDR, 0, 0, v);
        chk(v, 8'h80);
        chk(lp, 1);
        sfr(CCTC_TRIM_ADDR, 1, 8'h3F, v);
        sfr(CCTC_TRIM_ADDR, 0, 0, v);
        chk(v, 8'h3F);
        chk(rc_trim, 6'h3F);
        rst_i = 1;
        repeat (16) @(posedge clk_i);
        #1 rst_i = 0;
        repeat (2) @(posedge clk_i);
        check_reset();
        chk(lp, 0);
        complete_run();
    end
endmodule
